//--- rtl/charger_adc_gate_config_regs.sv
/*
 * Byte-addressed register slice: three measurement results, gate drive strength,
 * dead time, identification and reverse-mode discharge control.
 * Assumes a serial-bus front end presents single-cycle read/write strobes with
 * an 8-bit address, and the converter presents results with a load strobe.
 */
`timescale 1ns/1ps
// Behaviour
// - Battery voltage result is read-only, 2 mV per count, 0 to 7530h, clamped low and high, zero at reset.
// - Battery result low byte sits at 0x33 and high byte at 0x34.
// - Thermistor result high byte sits at 0x38 and low byte at 0x37.
// - Thermistor result is a regulator-rail ratio, 0 to 3FFh, clamped high, zero at reset.
// - Feedback result high byte sits at 0x3A and low byte at 0x39.
// - Feedback result is read-only, 1 mV per count, 0 to 7FFh, clamped high, zero at reset.
// - Strength bits 7:6 and 5:4 drive the boost and buck high-side switches, reset 00.
// - Strength bits 3:2 and 1:0 drive the boost and buck low-side switches, reset 00.
// - Dead time bits 3:2 boost and 1:0 buck select 45 to 135 ns, bits 7:4 read zero.
// - Identification is read-only with bit 7 zero, part id at 6:3 and revision at 2:0.
// - Reverse register bits 7:6 select the discharge limit from 20A down to 5A, reset 00.
// - Reverse register bit 1 enables fast transient response, reset 1, other bits read zero.
module charger_adc_gate_config_regs #(
    parameter logic [3:0] PART_ID = charger_regs_pkg::PART_ID_DEFAULT,
    parameter logic [2:0] REVISION = charger_regs_pkg::REVISION_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic result_load,
    input wire logic [15:0] vbat_raw,
    input wire logic [15:0] therm_raw,
    input wire logic [15:0] fb_raw,
    output logic [1:0] boost_high_side_strength,
    output logic [1:0] buck_high_side_strength,
    output logic [1:0] boost_low_side_strength,
    output logic [1:0] buck_low_side_strength,
    output logic [1:0] boost_dead_time,
    output logic [1:0] buck_dead_time,
    output logic [1:0] reverse_discharge_limit,
    output logic reverse_fast_response_enable
);
    // ----------------------------------------------------------------
    // Result capture
    // ----------------------------------------------------------------
    logic [15:0] vbat_q, vbat_d, therm_q, therm_d, fb_q, fb_d;
    logic [15:0] vbat_c, therm_c, fb_c;

    // Battery reading arrives as two's complement; negatives clamp to zero
    result_clamp #(.MAX_CODE(charger_regs_pkg::VBAT_MAX), .SIGNED_LOW(1'b1)) u_vbat (
        .raw(vbat_raw),
        .clamped(vbat_c)
    );
    result_clamp #(.MAX_CODE(charger_regs_pkg::THERM_MAX), .SIGNED_LOW(1'b0)) u_therm (
        .raw(therm_raw),
        .clamped(therm_c)
    );
    result_clamp #(.MAX_CODE(charger_regs_pkg::FB_MAX), .SIGNED_LOW(1'b0)) u_fb (
        .raw(fb_raw),
        .clamped(fb_c)
    );

    always_comb
    begin
        vbat_d = vbat_q;
        therm_d = therm_q;
        fb_d = fb_q;
        if (result_load)
        begin
            vbat_d = vbat_c;
            therm_d = therm_c;
            fb_d = fb_c;
        end
    end

    // Results are measurements, so the register reset command leaves them alone
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vbat_q <= 16'h0000;
            therm_q <= 16'h0000;
            fb_q <= 16'h0000;
        end
        else
        begin
            vbat_q <= vbat_d;
            therm_q <= therm_d;
            fb_q <= fb_d;
        end
    end

    // ----------------------------------------------------------------
    // Writable configuration
    // ----------------------------------------------------------------
    logic [7:0] strength_q, strength_d, dead_q, dead_d, rev_q, rev_d;

    always_comb
    begin
        strength_d = strength_q;
        dead_d = dead_q;
        rev_d = rev_q;
        if (reg_reset)
        begin
            strength_d = charger_regs_pkg::STRENGTH_RESET;
            dead_d = charger_regs_pkg::DEAD_TIME_RESET;
            rev_d = charger_regs_pkg::REVERSE_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                charger_regs_pkg::ADDR_STRENGTH: strength_d = reg_wdata & charger_regs_pkg::STRENGTH_MASK;
                charger_regs_pkg::ADDR_DEAD_TIME: dead_d = reg_wdata & charger_regs_pkg::DEAD_TIME_MASK;
                charger_regs_pkg::ADDR_REVERSE: rev_d = reg_wdata & charger_regs_pkg::REVERSE_MASK;
                default: strength_d = strength_q;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strength_q <= charger_regs_pkg::STRENGTH_RESET;
            dead_q <= charger_regs_pkg::DEAD_TIME_RESET;
            rev_q <= charger_regs_pkg::REVERSE_RESET;
        end
        else
        begin
            strength_q <= strength_d;
            dead_q <= dead_d;
            rev_q <= rev_d;
        end
    end

    // Field outputs come straight from the stored flops
    assign boost_high_side_strength = strength_q[7:6];
    assign buck_high_side_strength = strength_q[5:4];
    assign boost_low_side_strength = strength_q[3:2];
    assign buck_low_side_strength = strength_q[1:0];
    assign boost_dead_time = dead_q[3:2];
    assign buck_dead_time = dead_q[1:0];
    assign reverse_discharge_limit = rev_q[7:6];
    assign reverse_fast_response_enable = rev_q[1];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d, ident;
    logic rvalid_q, rvalid_d;

    always_comb
    begin
        ident = {1'b0, PART_ID, REVISION};
        rvalid_d = reg_rd;
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                charger_regs_pkg::ADDR_VBAT_LO: rdata_d = vbat_q[7:0];
                charger_regs_pkg::ADDR_VBAT_HI: rdata_d = vbat_q[15:8];
                charger_regs_pkg::ADDR_THERM_LO: rdata_d = therm_q[7:0];
                charger_regs_pkg::ADDR_THERM_HI: rdata_d = therm_q[15:8];
                charger_regs_pkg::ADDR_FB_LO: rdata_d = fb_q[7:0];
                charger_regs_pkg::ADDR_FB_HI: rdata_d = fb_q[15:8];
                charger_regs_pkg::ADDR_STRENGTH: rdata_d = strength_q;
                charger_regs_pkg::ADDR_DEAD_TIME: rdata_d = dead_q;
                charger_regs_pkg::ADDR_IDENT: rdata_d = ident;
                charger_regs_pkg::ADDR_REVERSE: rdata_d = rev_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_vbat_range;
        @(posedge mclk) disable iff (sys_rst) vbat_q <= charger_regs_pkg::VBAT_MAX;
    endproperty
    a_vbat_range: assert property (p_vbat_range) else $error("battery result out of range");

    property p_vbat_neg;
        @(posedge mclk) disable iff (sys_rst) (result_load && vbat_raw[15]) |=> vbat_q == 16'h0000;
    endproperty
    a_vbat_neg: assert property (p_vbat_neg) else $error("negative battery reading not clamped");

    property p_vbat_hi_read;
        @(posedge mclk) disable iff (sys_rst)
            (reg_rd && reg_addr == charger_regs_pkg::ADDR_VBAT_HI && !result_load) |=> reg_rdata == vbat_q[15:8];
    endproperty
    a_vbat_hi_read: assert property (p_vbat_hi_read) else $error("battery high byte wrong");

    property p_therm_lo_read;
        @(posedge mclk) disable iff (sys_rst)
            (reg_rd && reg_addr == charger_regs_pkg::ADDR_THERM_LO && !result_load) |=> reg_rdata == therm_q[7:0];
    endproperty
    a_therm_lo_read: assert property (p_therm_lo_read) else $error("thermistor low byte wrong");

    property p_therm_clamp;
        @(posedge mclk) disable iff (sys_rst)
            (result_load && therm_raw > charger_regs_pkg::THERM_MAX) |=> therm_q == charger_regs_pkg::THERM_MAX;
    endproperty
    a_therm_clamp: assert property (p_therm_clamp) else $error("thermistor not clamped high");

    property p_fb_hi_read;
        @(posedge mclk) disable iff (sys_rst)
            (reg_rd && reg_addr == charger_regs_pkg::ADDR_FB_HI) |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_fb_hi_read: assert property (p_fb_hi_read) else $error("feedback high byte above range");

    property p_fb_clamp;
        @(posedge mclk) disable iff (sys_rst)
            (result_load && fb_raw > charger_regs_pkg::FB_MAX) |=> fb_q == charger_regs_pkg::FB_MAX;
    endproperty
    a_fb_clamp: assert property (p_fb_clamp) else $error("feedback not clamped high");

    property p_strength_wr;
        @(posedge mclk) disable iff (sys_rst)
            (reg_wr && !reg_reset && reg_addr == charger_regs_pkg::ADDR_STRENGTH)
            |=> {boost_high_side_strength, buck_high_side_strength} == $past(reg_wdata[7:4]);
    endproperty
    a_strength_wr: assert property (p_strength_wr) else $error("high-side strength not written");

    property p_low_side_wr;
        @(posedge mclk) disable iff (sys_rst)
            (reg_wr && !reg_reset && reg_addr == charger_regs_pkg::ADDR_STRENGTH)
            |=> {boost_low_side_strength, buck_low_side_strength} == $past(reg_wdata[3:0]);
    endproperty
    a_low_side_wr: assert property (p_low_side_wr) else $error("low-side strength not written");

    property p_dead_reserved;
        @(posedge mclk) disable iff (sys_rst) dead_q[7:4] == 4'h0;
    endproperty
    a_dead_reserved: assert property (p_dead_reserved) else $error("dead time reserved bits set");

    property p_ident_read;
        @(posedge mclk) disable iff (sys_rst)
            (reg_rd && reg_addr == charger_regs_pkg::ADDR_IDENT) |=> reg_rdata == {1'b0, PART_ID, REVISION};
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("identification wrong");

    property p_rev_reset;
        @(posedge mclk) disable iff (sys_rst)
            reg_reset |=> (reverse_fast_response_enable && reverse_discharge_limit == 2'b00 && strength_q == 8'h00);
    endproperty
    a_rev_reset: assert property (p_rev_reset) else $error("register reset not applied");

    property p_rev_reserved;
        @(posedge mclk) disable iff (sys_rst) (rev_q & ~charger_regs_pkg::REVERSE_MASK) == 8'h00;
    endproperty
    a_rev_reserved: assert property (p_rev_reserved) else $error("reverse reserved bits set");

    property p_ro_ignored;
        @(posedge mclk) disable iff (sys_rst)
            (reg_wr && !reg_reset && reg_addr == charger_regs_pkg::ADDR_IDENT) |=> $stable(strength_q) && $stable(rev_q);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write changed state");

    c_write_strength: cover property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == charger_regs_pkg::ADDR_STRENGTH);
    c_read_vbat: cover property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == charger_regs_pkg::ADDR_VBAT_LO);
    c_clamp_fb: cover property (@(posedge mclk) disable iff (sys_rst)
        result_load && fb_raw > charger_regs_pkg::FB_MAX);
    c_reg_reset: cover property (@(posedge mclk) disable iff (sys_rst)
        reg_reset && rev_q != charger_regs_pkg::REVERSE_RESET);
endmodule

//--- rtl/charger_regs_pkg.sv
/*
 * Register map constants for the charger result and gate configuration slice.
 * Assumes byte-wide register access with 8-bit addresses.
 */
package charger_regs_pkg;

    // ----------------------------------------------------------------
    // Byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_VBAT_LO = 8'h33;
    localparam logic [7:0] ADDR_VBAT_HI = 8'h34;
    localparam logic [7:0] ADDR_THERM_LO = 8'h37;
    localparam logic [7:0] ADDR_THERM_HI = 8'h38;
    localparam logic [7:0] ADDR_FB_LO = 8'h39;
    localparam logic [7:0] ADDR_FB_HI = 8'h3A;
    localparam logic [7:0] ADDR_STRENGTH = 8'h3B;
    localparam logic [7:0] ADDR_DEAD_TIME = 8'h3C;
    localparam logic [7:0] ADDR_IDENT = 8'h3D;
    localparam logic [7:0] ADDR_REVERSE = 8'h62;

    // ----------------------------------------------------------------
    // Result ranges
    // ----------------------------------------------------------------
    localparam logic [15:0] VBAT_MAX = 16'h7530;
    localparam logic [15:0] THERM_MAX = 16'h03FF;
    localparam logic [15:0] FB_MAX = 16'h07FF;

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] STRENGTH_RESET = 8'h00;
    localparam logic [7:0] STRENGTH_MASK = 8'hFF;
    localparam logic [7:0] DEAD_TIME_RESET = 8'h00;
    localparam logic [7:0] DEAD_TIME_MASK = 8'h0F;
    localparam logic [7:0] REVERSE_RESET = 8'h02;
    localparam logic [7:0] REVERSE_MASK = 8'hC2;

    // ----------------------------------------------------------------
    // Identification field layout
    // ----------------------------------------------------------------
    localparam int IDENT_PART_LSB = 3;
    localparam int IDENT_REV_LSB = 0;
    // Arbitrary neutral defaults
    localparam logic [3:0] PART_ID_DEFAULT = 4'h9;
    localparam logic [2:0] REVISION_DEFAULT = 3'h1;

endpackage

//--- rtl/result_clamp.sv
/*
 * Saturating limiter for one 16-bit measurement result.
 * Assumes an unsigned raw input; signed low-end clamping is folded in by
 * treating a set top bit as negative when enabled.
 */
`timescale 1ns/1ps
module result_clamp #(
    parameter logic [15:0] MAX_CODE = 16'hFFFF,
    parameter bit SIGNED_LOW = 1'b0
) (
    input wire logic [15:0] raw,
    output logic [15:0] clamped
);
    always_comb
    begin
        if (SIGNED_LOW && raw[15])
            clamped = 16'h0000;
        else if (raw > MAX_CODE)
            clamped = MAX_CODE;
        else
            clamped = raw;
    end
endmodule

//--- verif/reg_host.sv
/*
 * Host-side model of the byte register access port: single-byte write and read.
 * Assumes reg_rvalid and reg_rdata answer one cycle after the read strobe.
 */
`timescale 1ns/1ps
module reg_host (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

//--- verif/testbench.sv
/*
 * Self-checking bench for the charger register slice.
 * Assumes the host model drives the byte port and this bench drives results.
 */
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_reset = 1'b0;
    logic result_load = 1'b0;
    logic [15:0] vbat_raw = 16'h0000;
    logic [15:0] therm_raw = 16'h0000;
    logic [15:0] fb_raw = 16'h0000;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_wr, reg_rd, reg_rvalid, okv;
    logic [1:0] bhs, kqhs, bls, kqls, bdt, kqdt, lim;
    logic fast;
    int n_mismatch = 0;
    int checks = 0;
    logic [15:0] rv [4] = '{16'h8000, 16'h7531, 16'h1234, 16'hFFFF};
    logic [15:0] ev [4] = '{16'h0000, 16'h7530, 16'h1234, 16'h0000};
    logic [15:0] rt [4] = '{16'h0400, 16'h03FF, 16'h0001, 16'hFFFF};
    logic [15:0] et [4] = '{16'h03FF, 16'h03FF, 16'h0001, 16'h03FF};
    logic [15:0] rf [4] = '{16'h0900, 16'h07FF, 16'h0123, 16'h0800};
    logic [15:0] ef [4] = '{16'h07FF, 16'h07FF, 16'h0123, 16'h07FF};
    logic [7:0] d;
    logic [7:0] ident;

    always #20 mclk = ~mclk;

    reg_host i_reg_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    charger_adc_gate_config_regs i_charger_adc_gate_config_regs (.mclk(mclk), .sys_rst(sys_rst),
        .reg_reset(reg_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .result_load(result_load),
        .vbat_raw(vbat_raw), .therm_raw(therm_raw), .fb_raw(fb_raw), .boost_high_side_strength(bhs),
        .buck_high_side_strength(kqhs), .boost_low_side_strength(bls), .buck_low_side_strength(kqls),
        .boost_dead_time(bdt), .buck_dead_time(kqdt), .reverse_discharge_limit(lim),
        .reverse_fast_response_enable(fast));

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_reg_host.rd(a, rdv, okv);
        chk("read valid", {15'h0000, okv}, 16'h0001);
        chk($sformatf("register %h", a), {8'h00, rdv}, {8'h00, exp});
        // Valid is a one-cycle pulse, while read data holds until the next read
        @(posedge mclk);
        #1;
        chk("read valid drop", {15'h0000, reg_rvalid}, 16'h0000);
        chk("read data hold", {8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic fchk(input logic [14:0] exp);
        chk("field outputs", {1'b0, bhs, kqhs, bls, kqls, bdt, kqdt, lim, fast}, {1'b0, exp});
    endtask

    task automatic load(input logic [15:0] v, input logic [15:0] t, input logic [15:0] f);
        @(posedge mclk);
        #1;
        vbat_raw = v;
        therm_raw = t;
        fb_raw = f;
        result_load = 1'b1;
        @(posedge mclk);
        #1;
        result_load = 1'b0;
    endtask

    task automatic results;
        $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        ident = {1'b0, charger_regs_pkg::PART_ID_DEFAULT, charger_regs_pkg::REVISION_DEFAULT};
        repeat (4) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        fchk(15'h0001);
        rchk(8'h33, 8'h00);
        rchk(8'h37, 8'h00);
        rchk(8'h3A, 8'h00);
        rchk(8'h3B, 8'h00);
        rchk(8'h3C, 8'h00);
        rchk(8'h3D, ident);
        rchk(8'h62, 8'h02);
        rchk(8'h40, 8'h00);
        $display("test reset values done");
        // Each code of every two-bit field, on all seven fields at once
        for (int k = 0; k < 4; k++)
        begin
            d = 8'(k) * 8'h55;
            i_reg_host.wr(8'h3B, d);
            i_reg_host.wr(8'h3C, d);
            i_reg_host.wr(8'h62, d);
            fchk({d, 2'(k), 2'(k), 2'(k), d[1]});
            rchk(8'h3B, d);
            rchk(8'h3C, d & 8'h0F);
            rchk(8'h62, d & 8'hC2);
        end
        $display("test field codes done");
        for (int i = 0; i < 4; i++)
        begin
            load(rv[i], rt[i], rf[i]);
            rchk(8'h33, ev[i][7:0]);
            rchk(8'h34, ev[i][15:8]);
            rchk(8'h37, et[i][7:0]);
            rchk(8'h38, et[i][15:8]);
            rchk(8'h39, ef[i][7:0]);
            rchk(8'h3A, ef[i][15:8]);
        end
        $display("test results done");
        // Read-only and unmapped writes must leave everything as it was
        i_reg_host.wr(8'h37, 8'h00);
        i_reg_host.wr(8'h3A, 8'h00);
        i_reg_host.wr(8'h3D, 8'hFF);
        i_reg_host.wr(8'h40, 8'h5A);
        rchk(8'h37, 8'hFF);
        rchk(8'h3A, 8'h07);
        rchk(8'h3D, ident);
        rchk(8'h40, 8'h00);
        fchk(15'h7FFF);
        @(posedge mclk);
        #1;
        reg_reset = 1'b1;
        @(posedge mclk);
        #1;
        reg_reset = 1'b0;
        fchk(15'h0001);
        rchk(8'h62, 8'h02);
        rchk(8'h39, 8'hFF);
        $display("test protection and register reset done");
        i_reg_host.wr(8'h3B, 8'hA5);
        fchk(15'h5281);
        sys_rst = 1'b1;
        @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        fchk(15'h0001);
        rchk(8'h39, 8'h00);
        rchk(8'h37, 8'h00);
        $display("test mid-run reset done");
        results();
    end

    initial
    begin
        #400000;
        n_mismatch++;
        $display("ERROR watchdog expected finish seen timeout");
        results();
    end
endmodule
